// file: dv/pmtr_dmem_model.sv
// Data memory stand-in that records the writes of the table and ALU paths; when both hit one cell in a cycle, the ALU write wins.
`timescale 1ns/1ps
module pmtr_dmem_model (
  input  wire logic        clk_i,
  input  wire logic        dm_wr_i,
  input  wire logic [10:0] dm_addr_i,
  input  wire logic [7:0]  dm_data_i,
  input  wire logic        alu_wr_i,
  input  wire logic [10:0] alu_addr_i,
  input  wire logic [7:0]  alu_data_i,
  input  wire logic [10:0] peek_addr_i,
  output logic      [7:0]  peek_data_o
);
  // Cells never written stay unknown, so a missing write cannot pass as a match.
  logic [7:0] mem [2048];

  always_ff @(posedge clk_i) begin
    if (dm_wr_i) begin
      mem[dm_addr_i] <= dm_data_i;
    end
    if (alu_wr_i) begin
      mem[alu_addr_i] <= alu_data_i;
    end
  end

  assign peek_data_o = mem[peek_addr_i];
endmodule : pmtr_dmem_model

// file: dv/pmtr_top_tb.sv
// Self-checking testbench of the table read unit and its ALU result path.
`timescale 1ns/1ps
module pmtr_top_tb;
  logic        clk_i, resetn_i, pc_step_i, ptr_lo_wr_i, ptr_hi_wr_i, rd_req_i;
  logic        latch_wr_i, alu_req_i, status_wr_i, load_en_i;
  logic [7:0]  ptr_wdata_i, latch_wdata_i, alu_a_i, alu_b_i, status_wdata_i;
  logic [10:0] rd_dest_i, alu_dest_i, peek_addr;
  logic [15:0] load_addr_i, load_data_i, pc_o;
  logic [7:0]  ptr_lo_o, ptr_hi_o, dm_data_o, table_high_latch_o, alu_data_o, status_o;
  logic [7:0]  peek_data;
  logic        rd_ready_o, rd_refused_o, dm_wr_o, alu_wr_o;
  logic [10:0] dm_addr_o, alu_addr_o;
  pmtr_pkg::pmtr_rd_t     rd_op_i;
  pmtr_pkg::pmtr_alu_op_t alu_op_i;
  int          errors;
  int          samples_checked;

  // A small memory and six implemented high bits keep the masking visible.
  pmtr_top #(.DEPTH(8192), .HI_IMPL_W(6)) pmtr_top_inst (
    .clk_i, .resetn_i, .pc_step_i, .pc_o, .ptr_lo_wr_i, .ptr_hi_wr_i, .ptr_wdata_i,
    .ptr_lo_o, .ptr_hi_o, .rd_req_i, .rd_op_i, .rd_dest_i, .rd_ready_o, .rd_refused_o,
    .dm_wr_o, .dm_addr_o, .dm_data_o, .latch_wr_i, .latch_wdata_i, .table_high_latch_o,
    .alu_req_i, .alu_op_i, .alu_a_i, .alu_b_i, .alu_dest_i, .alu_wr_o, .alu_addr_o,
    .alu_data_o, .status_wr_i, .status_wdata_i, .status_o, .load_en_i, .load_addr_i,
    .load_data_i);

  pmtr_dmem_model pmtr_dmem_model_inst (
    .clk_i(clk_i), .dm_wr_i(dm_wr_o), .dm_addr_i(dm_addr_o), .dm_data_i(dm_data_o),
    .alu_wr_i(alu_wr_o), .alu_addr_i(alu_addr_o), .alu_data_i(alu_data_o),
    .peek_addr_i(peek_addr), .peek_data_o(peek_data));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset(input int n);
    resetn_i = 1'b0;
    repeat (n) @(negedge clk_i);
    resetn_i = 1'b1;
  endtask : do_reset

  task automatic set_ptr(input logic [7:0] lo, input logic [7:0] hi);
    ptr_lo_wr_i = 1'b1;
    ptr_wdata_i = lo;
    @(negedge clk_i);
    ptr_lo_wr_i = 1'b0;
    ptr_hi_wr_i = 1'b1;
    ptr_wdata_i = hi;
    @(negedge clk_i);
    ptr_hi_wr_i = 1'b0;
    chk("ptr_lo_o", 16'(lo), 16'(ptr_lo_o));
    chk("ptr_hi_o", 16'(hi), 16'(ptr_hi_o));
  endtask : set_ptr

  task automatic rd(input pmtr_pkg::pmtr_rd_t op, input logic [10:0] dest,
                    input logic [7:0] ed, input logic [7:0] eh, input logic poke);
    rd_op_i = op;
    rd_dest_i = dest;
    rd_req_i = 1'b1;
    @(negedge clk_i);
    rd_req_i = poke;
    chk("rd_ready_o busy", 16'h0000, 16'(rd_ready_o));
    chk("dm_wr_o early", 16'h0000, 16'(dm_wr_o));
    @(negedge clk_i);
    chk("dm_wr_o", 16'h0001, 16'(dm_wr_o));
    chk("dm_addr_o", 16'(dest), 16'(dm_addr_o));
    chk("dm_data_o", 16'(ed), 16'(dm_data_o));
    chk("table_high_latch_o", 16'(eh), 16'(table_high_latch_o));
    chk("rd_ready_o idle", 16'h0001, 16'(rd_ready_o));
  endtask : rd

  task automatic t_reset_pc;
    chk("pc_o reset", 16'h0000, pc_o);
    chk("latch reset", 16'h0000, 16'(table_high_latch_o));
    chk("status reset", 16'h0000, 16'(status_o));
    chk("rd_ready_o reset", 16'h0001, 16'(rd_ready_o));
    pc_step_i = 1'b1;
    repeat (3) @(negedge clk_i);
    pc_step_i = 1'b0;
    chk("pc_o step", 16'h0003, pc_o);
    do_reset(2);
    chk("pc_o second reset", 16'h0000, pc_o);
    pc_step_i = 1'b1;
    repeat (3) @(negedge clk_i);
    pc_step_i = 1'b0;
  endtask : t_reset_pc

  task automatic t_table;
    // The trap word at 0x0006 catches a page taken from the counter or from zero.
    logic [15:0] la [4] = '{16'h0306, 16'h1F06, 16'h1F05, 16'h0006};
    logic [15:0] ld [4] = '{16'hA50F, 16'hC71A, 16'h7E2B, 16'h5555};
    for (int i = 0; i < 4; i++) begin
      load_en_i = 1'b1;
      load_addr_i = la[i];
      load_data_i = ld[i];
      @(negedge clk_i);
    end
    load_en_i = 1'b0;
    set_ptr(8'h06, 8'h03);
    rd(pmtr_pkg::PMTR_RD_PAGE, 11'h010, 8'h0F, 8'h25, 1'b0);
    rd(pmtr_pkg::PMTR_RD_LAST, 11'h011, 8'h1A, 8'h07, 1'b0);
    rd(pmtr_pkg::PMTR_RD_FAR_PAGE, 11'h512, 8'h0F, 8'h25, 1'b0);
    rd(pmtr_pkg::PMTR_RD_FAR_LAST, 11'h713, 8'h1A, 8'h07, 1'b1);
    rd_req_i = 1'b0;
    @(negedge clk_i);
    chk("dm_wr_o after busy request", 16'h0000, 16'(dm_wr_o));
    set_ptr(8'h05, 8'h03);
    rd(pmtr_pkg::PMTR_RD_LAST, 11'h020, 8'h2B, 8'h3E, 1'b0);
    @(negedge clk_i);
    peek_addr = 11'h512;
    #1 chk("dmem far", 16'h000F, 16'(peek_data));
    peek_addr = 11'h020;
    #1 chk("dmem last", 16'h002B, 16'(peek_data));
    @(negedge clk_i);
  endtask : t_table

  task automatic t_refuse;
    rd_op_i = pmtr_pkg::PMTR_RD_PAGE;
    rd_dest_i = 11'h234;
    rd_req_i = 1'b1;
    @(negedge clk_i);
    rd_req_i = 1'b0;
    chk("rd_refused_o", 16'h0001, 16'(rd_refused_o));
    @(negedge clk_i);
    chk("dm_wr_o refused", 16'h0000, 16'(dm_wr_o));
    chk("latch kept", 16'h003E, 16'(table_high_latch_o));
  endtask : t_refuse

  task automatic t_latch;
    // Saving and restoring the latch is how shared table code stays safe.
    logic [7:0] saved;
    saved = table_high_latch_o;
    latch_wr_i = 1'b1;
    latch_wdata_i = 8'h5A;
    @(negedge clk_i);
    latch_wdata_i = saved;
    @(negedge clk_i);
    latch_wr_i = 1'b0;
    chk("latch restored", 16'h003E, 16'(table_high_latch_o));
    latch_wr_i = 1'b1;
    latch_wdata_i = 8'h5A;
    @(negedge clk_i);
    latch_wr_i = 1'b0;
    chk("latch written", 16'h005A, 16'(table_high_latch_o));
  endtask : t_latch

  task automatic alu(input pmtr_pkg::pmtr_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] er, input logic ec, input logic ez);
    alu_op_i = op;
    alu_a_i = a;
    alu_b_i = b;
    alu_dest_i = {3'h1, a};
    alu_req_i = 1'b1;
    @(negedge clk_i);
    alu_req_i = 1'b0;
    chk("alu_wr_o", 16'h0001, 16'(alu_wr_o));
    chk("alu_addr_o", 16'({3'h1, a}), 16'(alu_addr_o));
    chk("alu_data_o", 16'(er), 16'(alu_data_o));
    chk("status C", 16'(ec), 16'(status_o[pmtr_pkg::ST_C_POS]));
    chk("status Z", 16'(ez), 16'(status_o[pmtr_pkg::ST_Z_POS]));
    @(negedge clk_i);
  endtask : alu

  task automatic t_alu;
    status_wr_i = 1'b1;
    status_wdata_i = 8'hA0;
    @(negedge clk_i);
    status_wr_i = 1'b0;
    chk("status soft bits", 16'h000A, 16'(status_o[7:4]));
    alu(pmtr_pkg::PMTR_ADD, 8'hF0, 8'h20, 8'h10, 1'b1, 1'b0);
    alu(pmtr_pkg::PMTR_AND, 8'hF0, 8'h0F, 8'h00, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_SUB, 8'h03, 8'h05, 8'hFE, 1'b0, 1'b0);
    alu(pmtr_pkg::PMTR_RR, 8'h01, 8'h00, 8'h80, 1'b0, 1'b0);
    alu(pmtr_pkg::PMTR_SUB, 8'h05, 8'h05, 8'h00, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_ADC, 8'h10, 8'h20, 8'h31, 1'b0, 1'b0);
    alu(pmtr_pkg::PMTR_RLC, 8'h80, 8'h00, 8'h00, 1'b1, 1'b0);
    alu(pmtr_pkg::PMTR_SBC, 8'h05, 8'h05, 8'h00, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_RRC, 8'h01, 8'h00, 8'h80, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_RL, 8'h81, 8'h00, 8'h03, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_OR, 8'h0F, 8'hF0, 8'hFF, 1'b1, 1'b0);
    alu(pmtr_pkg::PMTR_XOR, 8'hFF, 8'hFF, 8'h00, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_CPL, 8'h00, 8'h00, 8'hFF, 1'b1, 1'b0);
    alu(pmtr_pkg::PMTR_INC, 8'hFF, 8'h00, 8'h00, 1'b1, 1'b1);
    alu(pmtr_pkg::PMTR_DEC, 8'h00, 8'h00, 8'hFF, 1'b1, 1'b0);
    alu(pmtr_pkg::PMTR_ADD, 8'h09, 8'h08, 8'h11, 1'b0, 1'b0);
    alu(pmtr_pkg::PMTR_DAA, 8'h11, 8'h00, 8'h17, 1'b0, 1'b0);
    peek_addr = 11'h105;
    #1 chk("dmem alu", 16'h0000, 16'(peek_data));
  endtask : t_alu

  initial begin
    {pc_step_i, ptr_lo_wr_i, ptr_hi_wr_i, rd_req_i, latch_wr_i} = '0;
    {alu_req_i, status_wr_i, load_en_i} = '0;
    {ptr_wdata_i, latch_wdata_i, alu_a_i, alu_b_i, status_wdata_i} = '0;
    {rd_dest_i, alu_dest_i, peek_addr, load_addr_i, load_data_i} = '0;
    rd_op_i = pmtr_pkg::PMTR_RD_PAGE;
    alu_op_i = pmtr_pkg::PMTR_ADD;
    errors = 0;
    samples_checked = 0;
    do_reset(16);
    t_reset_pc();
    t_table();
    t_refuse();
    t_latch();
    t_alu();
    end_sim();
  end

  // The run needs under a hundred cycles; this margin only trips on a hang.
  initial begin
    #50000;
    errors++;
    end_sim();
  end
endmodule : pmtr_top_tb

// file: rtl/pmtr_alu.sv
// Eight-bit arithmetic and logic unit with status flag results.
`timescale 1ns/1ps
module pmtr_alu (
  input  wire pmtr_pkg::pmtr_alu_op_t op_i,
  input  wire logic [7:0]             a_i,
  input  wire logic [7:0]             b_i,
  input  wire logic [3:0]             status_i,
  output logic      [7:0]             result_o,
  output logic      [3:0]             flags_o,
  output logic      [3:0]             affect_o
);

  logic [8:0] sum;
  logic [4:0] half;
  logic       cin;

  always_comb begin
    cin      = status_i[pmtr_pkg::ST_C_POS];
    sum      = 9'h000;
    half     = 5'h00;
    result_o = 8'h00;
    flags_o  = 4'h0;
    affect_o = pmtr_pkg::FL_Z;
    case (op_i)
      pmtr_pkg::PMTR_ADD, pmtr_pkg::PMTR_ADC: begin
        sum  = {1'b0, a_i} + {1'b0, b_i} + {8'h00, (op_i == pmtr_pkg::PMTR_ADC) & cin};
        half = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, (op_i == pmtr_pkg::PMTR_ADC) & cin};
        affect_o = pmtr_pkg::FL_ARITH;
      end
      pmtr_pkg::PMTR_SUB, pmtr_pkg::PMTR_SBC: begin
        // Carry set means no borrow, so subtraction adds the complement.
        sum  = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, (op_i == pmtr_pkg::PMTR_SUB) | cin};
        half = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, (op_i == pmtr_pkg::PMTR_SUB) | cin};
        affect_o = pmtr_pkg::FL_ARITH;
      end
      pmtr_pkg::PMTR_AND: result_o = a_i & b_i;
      pmtr_pkg::PMTR_OR:  result_o = a_i | b_i;
      pmtr_pkg::PMTR_XOR: result_o = a_i ^ b_i;
      pmtr_pkg::PMTR_CPL: result_o = ~a_i;
      pmtr_pkg::PMTR_INC: result_o = a_i + 8'h01;
      pmtr_pkg::PMTR_DEC: result_o = a_i - 8'h01;
      pmtr_pkg::PMTR_RR: begin
        result_o = {a_i[0], a_i[7:1]};
        affect_o = pmtr_pkg::FL_NONE;
      end
      pmtr_pkg::PMTR_RL: begin
        result_o = {a_i[6:0], a_i[7]};
        affect_o = pmtr_pkg::FL_NONE;
      end
      pmtr_pkg::PMTR_RRC: begin
        result_o = {cin, a_i[7:1]};
        flags_o[pmtr_pkg::ST_C_POS] = a_i[0];
        affect_o = pmtr_pkg::FL_C;
      end
      pmtr_pkg::PMTR_RLC: begin
        result_o = {a_i[6:0], cin};
        flags_o[pmtr_pkg::ST_C_POS] = a_i[7];
        affect_o = pmtr_pkg::FL_C;
      end
      pmtr_pkg::PMTR_DAA: begin
        sum = {1'b0, a_i};
        if ((a_i[3:0] > 4'h9) || status_i[pmtr_pkg::ST_AC_POS]) begin
          sum = sum + 9'h006;
        end
        if ((sum[7:4] > 4'h9) || sum[8] || cin) begin
          sum = sum + 9'h060;
        end
        result_o = sum[7:0];
        flags_o[pmtr_pkg::ST_C_POS] = sum[8] | cin;
        affect_o = pmtr_pkg::FL_C;
      end
      default: result_o = a_i;
    endcase
    if (affect_o == pmtr_pkg::FL_ARITH) begin
      result_o = sum[7:0];
      flags_o[pmtr_pkg::ST_C_POS]  = sum[8];
      flags_o[pmtr_pkg::ST_AC_POS] = half[4];
      flags_o[pmtr_pkg::ST_OV_POS] = sum[8] ^ sum[7] ^ a_i[7] ^ b_i[7]
                                     ^ ((op_i == pmtr_pkg::PMTR_SUB) | (op_i == pmtr_pkg::PMTR_SBC));
    end
    flags_o[pmtr_pkg::ST_Z_POS] = (result_o == 8'h00);
  end

endmodule : pmtr_alu

// file: rtl/pmtr_pkg.sv
// Shared constants and types of the program-memory table read unit.
package pmtr_pkg;

  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned DM_ADDR_W    = 11;
  localparam int unsigned SECTOR_LSB   = 8;
  localparam int unsigned SECTOR_W     = 3;

  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  LATCH_RESET  = 8'h00;
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  LAST_PAGE    = 8'hFF;
  localparam logic [2:0]  SECTOR_ZERO  = 3'h0;

  localparam int unsigned ST_C_POS     = 0;
  localparam int unsigned ST_AC_POS    = 1;
  localparam int unsigned ST_Z_POS     = 2;
  localparam int unsigned ST_OV_POS    = 3;

  localparam logic [3:0]  FL_NONE      = 4'h0;
  localparam logic [3:0]  FL_Z         = 4'h4;
  localparam logic [3:0]  FL_C         = 4'h1;
  localparam logic [3:0]  FL_ARITH     = 4'hF;

  localparam int unsigned READ_CYCLES  = 2;

  typedef enum logic [1:0] {
    PMTR_RD_PAGE,
    PMTR_RD_LAST,
    PMTR_RD_FAR_PAGE,
    PMTR_RD_FAR_LAST
  } pmtr_rd_t;

  typedef enum logic [3:0] {
    PMTR_ADD, PMTR_ADC, PMTR_SUB, PMTR_SBC,
    PMTR_AND, PMTR_OR,  PMTR_XOR, PMTR_CPL,
    PMTR_RR,  PMTR_RL,  PMTR_RRC, PMTR_RLC,
    PMTR_INC, PMTR_DEC, PMTR_DAA
  } pmtr_alu_op_t;

endpackage : pmtr_pkg

// file: rtl/pmtr_rom.sv
// Program memory array with a synchronous table read port and a preload port.
`timescale 1ns/1ps
module pmtr_rom #(
  parameter int unsigned DEPTH  = 65536,
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned WORD_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rd_en_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [WORD_W-1:0] rd_data_o,
  input  wire logic              load_en_i,
  input  wire logic [ADDR_W-1:0] load_addr_i,
  input  wire logic [WORD_W-1:0] load_data_i
);

  logic [WORD_W-1:0] mem [DEPTH];

  // Array cells carry no reset, which keeps the memory inferable as a block RAM.
  always_ff @(posedge clk_i) begin
    if (load_en_i) begin
      mem[load_addr_i] <= load_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule : pmtr_rom

// file: rtl/pmtr_top.sv
// Table read unit, reset vector counter and ALU result path of the processor.
`timescale 1ns/1ps
module pmtr_top #(
  parameter int unsigned DEPTH      = 65536,
  parameter int unsigned HI_IMPL_W  = 8
) (
  input  wire logic                                clk_i,
  input  wire logic                                resetn_i,
  input  wire logic                                pc_step_i,
  output logic      [15:0]                         pc_o,
  input  wire logic                                ptr_lo_wr_i,
  input  wire logic                                ptr_hi_wr_i,
  input  wire logic [7:0]                          ptr_wdata_i,
  output logic      [7:0]                          ptr_lo_o,
  output logic      [7:0]                          ptr_hi_o,
  input  wire logic                                rd_req_i,
  input  wire pmtr_pkg::pmtr_rd_t                  rd_op_i,
  input  wire logic [pmtr_pkg::DM_ADDR_W-1:0]      rd_dest_i,
  output logic                                     rd_ready_o,
  output logic                                     rd_refused_o,
  output logic                                     dm_wr_o,
  output logic      [pmtr_pkg::DM_ADDR_W-1:0]      dm_addr_o,
  output logic      [7:0]                          dm_data_o,
  input  wire logic                                latch_wr_i,
  input  wire logic [7:0]                          latch_wdata_i,
  output logic      [7:0]                          table_high_latch_o,
  input  wire logic                                alu_req_i,
  input  wire pmtr_pkg::pmtr_alu_op_t              alu_op_i,
  input  wire logic [7:0]                          alu_a_i,
  input  wire logic [7:0]                          alu_b_i,
  input  wire logic [pmtr_pkg::DM_ADDR_W-1:0]      alu_dest_i,
  output logic                                     alu_wr_o,
  output logic      [pmtr_pkg::DM_ADDR_W-1:0]      alu_addr_o,
  output logic      [7:0]                          alu_data_o,
  input  wire logic                                status_wr_i,
  input  wire logic [7:0]                          status_wdata_i,
  output logic      [7:0]                          status_o,
  input  wire logic                                load_en_i,
  input  wire logic [pmtr_pkg::ADDR_W-1:0]         load_addr_i,
  input  wire logic [pmtr_pkg::WORD_W-1:0]         load_data_i
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef enum logic {
    PMTR_IDLE,
    PMTR_FETCH
  } pmtr_state_t;

  pmtr_state_t                        state_ff;
  pmtr_state_t                        nxt_state;
  logic [15:0]                        pc_ff;
  logic [15:0]                        nxt_pc;
  logic [7:0]                         ptr_lo_ff;
  logic [7:0]                         nxt_ptr_lo;
  logic [7:0]                         ptr_hi_ff;
  logic [7:0]                         nxt_ptr_hi;
  logic [7:0]                         latch_ff;
  logic [7:0]                         nxt_latch;
  logic [pmtr_pkg::DM_ADDR_W-1:0]     dest_ff;
  logic [pmtr_pkg::DM_ADDR_W-1:0]     nxt_dest;
  logic                               dm_wr_ff;
  logic                               nxt_dm_wr;
  logic [pmtr_pkg::DM_ADDR_W-1:0]     dm_addr_ff;
  logic [pmtr_pkg::DM_ADDR_W-1:0]     nxt_dm_addr;
  logic [7:0]                         dm_data_ff;
  logic [7:0]                         nxt_dm_data;
  logic                               refused_ff;
  logic                               nxt_refused;
  logic [7:0]                         status_ff;
  logic [7:0]                         nxt_status;
  logic                               alu_wr_ff;
  logic                               nxt_alu_wr;
  logic [pmtr_pkg::DM_ADDR_W-1:0]     alu_addr_ff;
  logic [pmtr_pkg::DM_ADDR_W-1:0]     nxt_alu_addr;
  logic [7:0]                         alu_data_ff;
  logic [7:0]                         nxt_alu_data;
  logic                               take;
  logic                               short_op;
  logic                               last_page;
  logic [7:0]                         page;
  logic [15:0]                        tab_addr;
  logic [pmtr_pkg::WORD_W-1:0]        word;
  logic [7:0]                         hi_mask;
  logic [7:0]                         alu_res;
  logic [3:0]                         alu_flags;
  logic [3:0]                         alu_affect;

  // Address decode of the table request.
  always_comb begin
    short_op  = (rd_op_i == pmtr_pkg::PMTR_RD_PAGE) || (rd_op_i == pmtr_pkg::PMTR_RD_LAST);
    last_page = (rd_op_i == pmtr_pkg::PMTR_RD_LAST) || (rd_op_i == pmtr_pkg::PMTR_RD_FAR_LAST);
    page      = last_page ? pmtr_pkg::LAST_PAGE : ptr_hi_ff;
    tab_addr  = {page, ptr_lo_ff};
    // A short form aimed outside sector zero is refused and writes nothing.
    take      = rd_req_i && (state_ff == PMTR_IDLE)
                && !(short_op && (rd_dest_i[pmtr_pkg::SECTOR_LSB +: pmtr_pkg::SECTOR_W]
                                  != pmtr_pkg::SECTOR_ZERO));
    hi_mask   = 8'(({8'h00, 8'hFF} >> (8 - HI_IMPL_W)) & 16'h00FF);
  end

  pmtr_rom #(
    .DEPTH  (DEPTH),
    .ADDR_W (AW),
    .WORD_W (pmtr_pkg::WORD_W)
  ) u_rom (
    .clk_i       (clk_i),
    .rd_en_i     (take),
    .rd_addr_i   (tab_addr[AW-1:0]),
    .rd_data_o   (word),
    .load_en_i   (load_en_i),
    .load_addr_i (load_addr_i[AW-1:0]),
    .load_data_i (load_data_i)
  );

  pmtr_alu u_alu (
    .op_i     (alu_op_i),
    .a_i      (alu_a_i),
    .b_i      (alu_b_i),
    .status_i (status_ff[3:0]),
    .result_o (alu_res),
    .flags_o  (alu_flags),
    .affect_o (alu_affect)
  );

  // Table read sequencing, pointers and latch.
  always_comb begin
    nxt_state   = state_ff;
    nxt_pc      = pc_step_i ? pc_ff + 16'h0001 : pc_ff;
    nxt_ptr_lo  = ptr_lo_wr_i ? ptr_wdata_i : ptr_lo_ff;
    nxt_ptr_hi  = ptr_hi_wr_i ? ptr_wdata_i : ptr_hi_ff;
    nxt_latch   = latch_wr_i ? latch_wdata_i : latch_ff;
    nxt_dest    = dest_ff;
    nxt_dm_wr   = 1'b0;
    nxt_dm_addr = dm_addr_ff;
    nxt_dm_data = dm_data_ff;
    nxt_refused = rd_req_i && (state_ff == PMTR_IDLE) && !take;
    case (state_ff)
      PMTR_IDLE: begin
        if (take) begin
          nxt_dest  = rd_dest_i;
          nxt_state = PMTR_FETCH;
        end
      end
      PMTR_FETCH: begin
        nxt_dm_wr   = 1'b1;
        nxt_dm_addr = dest_ff;
        nxt_dm_data = word[7:0];
        // The hardware load wins over a software write in the same cycle.
        nxt_latch   = word[15:8] & hi_mask;
        nxt_state   = PMTR_IDLE;
      end
      default: nxt_state = PMTR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff   <= PMTR_IDLE;
      pc_ff      <= pmtr_pkg::PC_RESET;
      ptr_lo_ff  <= pmtr_pkg::PTR_RESET;
      ptr_hi_ff  <= pmtr_pkg::PTR_RESET;
      latch_ff   <= pmtr_pkg::LATCH_RESET;
      dest_ff    <= '0;
      dm_wr_ff   <= 1'b0;
      dm_addr_ff <= '0;
      dm_data_ff <= 8'h00;
      refused_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      pc_ff      <= nxt_pc;
      ptr_lo_ff  <= nxt_ptr_lo;
      ptr_hi_ff  <= nxt_ptr_hi;
      latch_ff   <= nxt_latch;
      dest_ff    <= nxt_dest;
      dm_wr_ff   <= nxt_dm_wr;
      dm_addr_ff <= nxt_dm_addr;
      dm_data_ff <= nxt_dm_data;
      refused_ff <= nxt_refused;
    end
  end

  // Status flags and result write-back of the ALU.
  always_comb begin
    nxt_status   = status_wr_i ? status_wdata_i : status_ff;
    nxt_alu_wr   = alu_req_i;
    nxt_alu_addr = alu_req_i ? alu_dest_i : alu_addr_ff;
    nxt_alu_data = alu_req_i ? alu_res : alu_data_ff;
    if (alu_req_i) begin
      // Only the flags that the operation affects change.
      nxt_status[3:0] = (status_ff[3:0] & ~alu_affect) | (alu_flags & alu_affect);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_ff   <= pmtr_pkg::STATUS_RESET;
      alu_wr_ff   <= 1'b0;
      alu_addr_ff <= '0;
      alu_data_ff <= 8'h00;
    end else begin
      status_ff   <= nxt_status;
      alu_wr_ff   <= nxt_alu_wr;
      alu_addr_ff <= nxt_alu_addr;
      alu_data_ff <= nxt_alu_data;
    end
  end

  assign pc_o               = pc_ff;
  assign ptr_lo_o           = ptr_lo_ff;
  assign ptr_hi_o           = ptr_hi_ff;
  assign rd_ready_o         = (state_ff == PMTR_IDLE);
  assign rd_refused_o       = refused_ff;
  assign dm_wr_o            = dm_wr_ff;
  assign dm_addr_o          = dm_addr_ff;
  assign dm_data_o          = dm_data_ff;
  assign table_high_latch_o = latch_ff;
  assign alu_wr_o           = alu_wr_ff;
  assign alu_addr_o         = alu_addr_ff;
  assign alu_data_o         = alu_data_ff;
  assign status_o           = status_ff;

  AST_PC_RESET: assert property (@(posedge clk_i) $rose(resetn_i) |-> pc_o == 16'h0000)
    else $error("Program counter not at zero after reset.");

  AST_TWO_CYCLES: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take |=> !rd_ready_o ##1 (dm_wr_o && rd_ready_o))
    else $error("Table read did not complete in two cycles.");

  AST_DEST_ADDR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take |-> ##2 dm_addr_o == $past(rd_dest_i, 2))
    else $error("Table low byte written to wrong register.");

  AST_SECTOR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_req_i && rd_ready_o && short_op && rd_dest_i[10:8] != 3'h0) |=> rd_refused_o
    ##1 !dm_wr_o)
    else $error("Short table read outside sector zero was taken.");

  AST_LATCH_LOAD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dm_wr_o |-> table_high_latch_o == $past(word[15:8] & hi_mask))
    else $error("Table high latch not loaded with high byte.");

  AST_HI_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dm_wr_o |-> (table_high_latch_o & ~hi_mask) == 8'h00)
    else $error("Unimplemented latch bits not zero.");

  AST_PTR_ADDR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (take && rd_op_i == pmtr_pkg::PMTR_RD_PAGE) |-> tab_addr == {ptr_hi_o, ptr_lo_o})
    else $error("Table address not formed from pointer bytes.");

  AST_LATCH_RW: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (latch_wr_i && state_ff == PMTR_IDLE) |=> table_high_latch_o == $past(latch_wdata_i))
    else $error("Software write to table high latch lost.");

  AST_ALU_WB: assert property (@(posedge clk_i) disable iff (!resetn_i)
    alu_req_i |=> alu_wr_o && alu_addr_o == $past(alu_dest_i)
                  && alu_data_o == $past(alu_res))
    else $error("ALU result not written to destination.");

  // Rotates and decimal adjust leave the zero flag alone, so only operations that own it count.
  AST_ALU_Z: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (alu_req_i && !status_wr_i && alu_affect[pmtr_pkg::ST_Z_POS])
    |=> status_o[2] == (alu_data_o == 8'h00))
    else $error("Zero flag does not match ALU result.");

  AST_LOW_BYTE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dm_wr_o |-> dm_data_o == $past(word[7:0]))
    else $error("Table low byte differs from the word read.");

  AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!$past(latch_wr_i) && !dm_wr_o) |-> $stable(table_high_latch_o))
    else $error("Table high latch changed without a load or write.");

  AST_SECTOR_FAR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_req_i && rd_ready_o && !short_op) |=> !rd_refused_o && !rd_ready_o)
    else $error("Far table read was refused.");

  AST_REFUSE_IDLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_refused_o |-> rd_ready_o && !dm_wr_o)
    else $error("Refused table read left the unit busy.");

  AST_BUSY_FIRST: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dm_wr_o |-> !$past(rd_ready_o))
    else $error("Table write without a busy cycle before it.");

  AST_STATUS_SOFT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (alu_req_i && !status_wr_i) |=> status_o[7:4] == $past(status_o[7:4]))
    else $error("ALU operation changed software status bits.");

  AST_PC_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pc_step_i |=> pc_o == $past(pc_o) + 16'h0001)
    else $error("Program counter did not step by one.");

endmodule : pmtr_top
